// ---- design/floppy_consts.svh ----
// Constants shared by both ends of the floppy host handshake.
// Assumes a 100 MHz core clock on both ends.
`ifndef FLOPPY_CONSTS_SVH
`define FLOPPY_CONSTS_SVH

// Clock rate in MHz.
`define FLP_CLK_MHZ 100

// Host timing: command line settle time and strobe width.
`define FLP_CMD_SETUP_NS 100
`define FLP_CMD_SETUP_CYC ((`FLP_CMD_SETUP_NS * `FLP_CLK_MHZ + 999) / 1000)
`define FLP_STROBE_NS 1000
`define FLP_STROBE_CYC ((`FLP_STROBE_NS * `FLP_CLK_MHZ + 999) / 1000)

// Device timing: least access delay and longest answer window.
`define FLP_ACCESS_MIN_US 1000
`define FLP_ACCESS_MIN_CYC (`FLP_ACCESS_MIN_US * `FLP_CLK_MHZ)
`define FLP_REPLY_MAX_US 64
`define FLP_REPLY_MAX_CYC (`FLP_REPLY_MAX_US * `FLP_CLK_MHZ)

// Words in one sector.
`define FLP_SECTOR_WORDS 128

// Host register byte offsets.
`define FLP_REG_CMD 8'h00
`define FLP_REG_WORD 8'h04
`define FLP_REG_RDATA 8'h08
`define FLP_REG_STATUS 8'h0c
`define FLP_REG_IRQ_STAT 8'h10
`define FLP_REG_IRQ_CLR 8'h14
`define FLP_REG_IRQ_EN 8'h18

// Interrupt status bit positions and reset values.
`define FLP_IRQ_DONE 0
`define FLP_IRQ_REQ 1
`define FLP_IRQ_LATE 2
`define FLP_IRQ_RST 3'h0

`endif

// ---- design/floppy_pkg.sv ----
// Types shared by both ends of the floppy host handshake.
// Assumes nothing beyond a SystemVerilog compiler.
package floppy_pkg;

	// Operation codes, in the order of their two-bit encoding.
	typedef enum logic [1:0] {
		OP_SELECT,
		OP_READ,
		OP_WRITE,
		OP_SEEK
	} op_e;

	// Layout of the sixteen-bit command word, most significant first.
	typedef struct packed {
		logic       spare;
		op_e        op;
		logic [1:0] drive;
		logic [6:0] track;
		logic [3:0] sector;
	} cmd_s;

endpackage : floppy_pkg

// ---- design/floppy_link_if.sv ----
// Parallel link between the host end and the device end.
// Assumes both ends run on their own clocks; every strobe is asynchronous.
`timescale 1ns/1ps
interface floppy_link_if;

	logic [15:0] cmd_word;
	logic        command_pulse_n;
	logic [15:0] wr_data;
	logic        word_strobe_n;
	logic [15:0] rd_data;
	logic        word_request_flag;
	logic        formatter_idle;
	logic        late_service_flag;
	logic        crc_fault_flag;

	// Device end of the link.
	modport dev (
		input  cmd_word, command_pulse_n, wr_data, word_strobe_n,
		output rd_data, word_request_flag, formatter_idle,
		output late_service_flag, crc_fault_flag
	);

	// Host end of the link.
	modport host (
		output cmd_word, command_pulse_n, wr_data, word_strobe_n,
		input  rd_data, word_request_flag, formatter_idle,
		input  late_service_flag, crc_fault_flag
	);

endinterface : floppy_link_if

// ---- design/floppy_device_end.sv ----
// Device end of the floppy host handshake: command capture, sector word
// requests with answer window, rate error and zero fill.
// Assumes a disk side that reports head arrival and paces word slots.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "floppy_consts.svh"
module floppy_device_end #(
	parameter int unsigned ACCESS_MIN_CYCLES = `FLP_ACCESS_MIN_CYC,
	parameter int unsigned REPLY_MAX_CYCLES  = `FLP_REPLY_MAX_CYC,
	parameter int unsigned SECTOR_WORDS      = `FLP_SECTOR_WORDS
) (
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	// Link to the host.
	floppy_link_if.dev       link,
	// Disk side status and read words.
	input  wire logic        disk_ready_in,
	input  wire logic        disk_slot_in,
	input  wire logic [15:0] disk_rd_data_in,
	input  wire logic        crc_error_in,
	// Disk side command and write words.
	output logic             cmd_start_out,
	output logic [15:0]      cmd_out,
	output logic             disk_wr_valid_out,
	output logic [15:0]      disk_wr_data_out
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARMED,
		ST_ACCESS,
		ST_SLOT,
		ST_PRESENT,
		ST_REQ
	} state_e;

	// Strobe synchronisers: bit 0 command, bit 1 word.
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] last_q;
	logic [1:0] fall;
	logic [1:0] rise;

	state_e          state_q, state_d;
	floppy_pkg::cmd_s cmd_q, cmd_d;
	logic [31:0]     wait_q, wait_d;
	logic [7:0]      words_q, words_d;
	logic [15:0]     rd_q, rd_d;
	logic [15:0]     hold_q, hold_d;
	logic [15:0]     wr_out_q, wr_out_d;
	logic            req_q, req_d;
	logic            idle_q, idle_d;
	logic            late_q, late_d;
	logic            crc_q, crc_d;
	logic            zero_q, zero_d;
	logic            have_q, have_d;
	logic            start_q, start_d;
	logic            wr_valid_q, wr_valid_d;
	logic            clr_flags;
	logic            late_set;
	logic            is_write;

	// Two flops before any logic, a third only for edge detection.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
			last_q <= 2'h3;
		end else begin
			meta_q <= {link.word_strobe_n, link.command_pulse_n};
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edge pulses last one cycle each.
	assign fall = last_q & ~sync_q;
	assign rise = ~last_q & sync_q;

	assign is_write = (cmd_q.op == floppy_pkg::OP_WRITE);

	// Sequencer next state.
	always_comb begin
		state_d    = state_q;
		cmd_d      = cmd_q;
		wait_d     = wait_q;
		words_d    = words_q;
		rd_d       = rd_q;
		hold_d     = hold_q;
		wr_out_d   = wr_out_q;
		req_d      = req_q;
		idle_d     = idle_q;
		zero_d     = zero_q;
		have_d     = have_q;
		start_d    = 1'b0;
		wr_valid_d = 1'b0;
		clr_flags  = 1'b0;
		late_set   = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// Commands strobed while busy are ignored.
				if (fall[0]) begin
					cmd_d     = link.cmd_word;
					clr_flags = 1'b1;
					state_d   = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (rise[0]) begin
					idle_d  = 1'b0;
					start_d = 1'b1;
					wait_d  = 32'h0;
					words_d = 8'h0;
					zero_d  = 1'b0;
					have_d  = 1'b0;
					if (cmd_q.op == floppy_pkg::OP_SELECT) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_ACCESS;
					end
				end
			end
			ST_ACCESS: begin
				if (wait_q != 32'hffffffff) begin
					wait_d = wait_q + 32'h1;
				end
				// A seek needs no minimum; data commands do.
				if (disk_ready_in) begin
					if (cmd_q.op == floppy_pkg::OP_SEEK) begin
						state_d = ST_IDLE;
					end else if (wait_q >= ACCESS_MIN_CYCLES - 1) begin
						state_d = ST_SLOT;
					end
				end
			end
			ST_SLOT: begin
				if (disk_slot_in) begin
					if (is_write && have_q) begin
						wr_valid_d = 1'b1;
						wr_out_d   = zero_q ? 16'h0 : hold_q;
						have_d     = 1'b0;
					end
					if (words_q == 8'(SECTOR_WORDS)) begin
						state_d = ST_IDLE;
					end else if (is_write && zero_q) begin
						have_d  = 1'b1;
						words_d = words_q + 8'h1;
					end else begin
						rd_d    = disk_rd_data_in;
						state_d = ST_PRESENT;
					end
				end
			end
			ST_PRESENT: begin
				// Read data has stood one cycle before the request rises.
				req_d   = 1'b1;
				wait_d  = 32'h0;
				state_d = ST_REQ;
			end
			ST_REQ: begin
				wait_d = wait_q + 32'h1;
				if (is_write && fall[1] && req_q) begin
					hold_d = link.wr_data;
					req_d  = 1'b0;
					have_d = 1'b1;
				end
				if (rise[1]) begin
					req_d   = 1'b0;
					words_d = words_q + 8'h1;
					state_d = ST_SLOT;
				end else if (wait_q >= REPLY_MAX_CYCLES - 1) begin
					late_set = 1'b1;
					req_d    = 1'b0;
					words_d  = words_q + 8'h1;
					state_d  = ST_SLOT;
					if (is_write) begin
						zero_d = 1'b1;
						have_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Idle returns once the sequencer settles back in idle. A select
		// passes from armed straight to idle, so idle stays low for that
		// one cycle and the host still sees that the command was taken.
		if (state_q != ST_ARMED && state_d == ST_IDLE) begin
			idle_d = 1'b1;
		end
		// A new event beats the clear of the same cycle.
		late_d = (late_q & ~clr_flags) | late_set;
		crc_d  = (crc_q & ~clr_flags) |
		         (crc_error_in && state_q != ST_IDLE);
	end

	// Sequencer registers.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_q    <= ST_IDLE;
			cmd_q      <= '0;
			wait_q     <= 32'h0;
			words_q    <= 8'h0;
			rd_q       <= 16'h0;
			hold_q     <= 16'h0;
			wr_out_q   <= 16'h0;
			req_q      <= 1'b0;
			idle_q     <= 1'b1;
			late_q     <= 1'b0;
			crc_q      <= 1'b0;
			zero_q     <= 1'b0;
			have_q     <= 1'b0;
			start_q    <= 1'b0;
			wr_valid_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cmd_q      <= cmd_d;
			wait_q     <= wait_d;
			words_q    <= words_d;
			rd_q       <= rd_d;
			hold_q     <= hold_d;
			wr_out_q   <= wr_out_d;
			req_q      <= req_d;
			idle_q     <= idle_d;
			late_q     <= late_d;
			crc_q      <= crc_d;
			zero_q     <= zero_d;
			have_q     <= have_d;
			start_q    <= start_d;
			wr_valid_q <= wr_valid_d;
		end
	end

	// All outputs come straight from flops.
	assign link.rd_data           = rd_q;
	assign link.word_request_flag = req_q;
	assign link.formatter_idle    = idle_q;
	assign link.late_service_flag = late_q;
	assign link.crc_fault_flag    = crc_q;
	assign cmd_start_out          = start_q;
	assign cmd_out                = cmd_q;
	assign disk_wr_valid_out      = wr_valid_q;
	assign disk_wr_data_out       = wr_out_q;

endmodule : floppy_device_end

// ---- design/floppy_host_end.sv ----
// Host end of the floppy handshake: APB registers, strobe generator and
// interrupt logic.
// Assumes software answers each word request within the device window.
`timescale 1ns/1ps
`include "floppy_consts.svh"
module floppy_host_end (
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Interrupt.
	output logic             irq_out,
	// Link to the device.
	floppy_link_if.host      link
);

	typedef enum logic [1:0] {
		H_IDLE,
		H_SETUP,
		H_PULSE
	} hstate_e;

	// Device status synchronisers: req, idle, late, crc.
	logic [3:0]  meta_q;
	logic [3:0]  sync_q;
	logic [3:0]  last_q;

	hstate_e     hs_q, hs_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        is_cmd_q, is_cmd_d;
	logic [15:0] cmd_q, cmd_d;
	logic [15:0] wr_q, wr_d;
	logic        cstb_n_q, cstb_n_d;
	logic        dstb_n_q, dstb_n_d;
	logic [15:0] rdat_q, rdat_d;
	logic [2:0]  ist_q, ist_d;
	logic [2:0]  ien_q, ien_d;
	logic [2:0]  ev;
	logic        wr_acc;

	// True for every offset that answers without error.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `FLP_REG_CMD) || (a == `FLP_REG_WORD) ||
		         (a == `FLP_REG_RDATA) || (a == `FLP_REG_STATUS) ||
		         (a == `FLP_REG_IRQ_STAT) || (a == `FLP_REG_IRQ_CLR) ||
		         (a == `FLP_REG_IRQ_EN);
	endfunction : mapped

	// Status lines arrive from another clock, so two flops first.
	always_ff @(posedge core_clk_in) begin
		// Idle is high after reset, so the flops start there and no
		// false done event follows the release of reset.
		if (sys_rst_in) begin
			meta_q <= 4'h2;
			sync_q <= 4'h2;
			last_q <= 4'h2;
		end else begin
			meta_q <= {link.crc_fault_flag, link.late_service_flag,
			           link.formatter_idle, link.word_request_flag};
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign ev     = sync_q[2:0] & ~last_q[2:0];
	assign wr_acc = psel_in & penable_in & pwrite_in;

	// Strobe sequencer and registers, next values.
	always_comb begin
		hs_d     = hs_q;
		cnt_d    = cnt_q;
		is_cmd_d = is_cmd_q;
		cmd_d    = cmd_q;
		wr_d     = wr_q;
		cstb_n_d = cstb_n_q;
		dstb_n_d = dstb_n_q;
		ien_d    = ien_q;
		// Read data stands still once the request is seen.
		rdat_d   = ev[0] ? link.rd_data : rdat_q;
		ist_d    = ist_q;
		if (wr_acc && paddr_in == `FLP_REG_IRQ_CLR) begin
			ist_d = ist_q & ~pwdata_in[2:0];
		end
		// Set wins over a clear in the same cycle.
		ist_d[`FLP_IRQ_DONE] = ist_d[`FLP_IRQ_DONE] | ev[1];
		ist_d[`FLP_IRQ_REQ]  = ist_d[`FLP_IRQ_REQ] | ev[0];
		ist_d[`FLP_IRQ_LATE] = ist_d[`FLP_IRQ_LATE] | ev[2];
		if (wr_acc && paddr_in == `FLP_REG_IRQ_EN) begin
			ien_d = pwdata_in[2:0];
		end
		case (hs_q)
			H_IDLE: begin
				// Orders written while a strobe is in flight are dropped.
				if (wr_acc && paddr_in == `FLP_REG_CMD) begin
					cmd_d    = pwdata_in[15:0];
					is_cmd_d = 1'b1;
					cnt_d    = 8'h0;
					hs_d     = H_SETUP;
				end else if (wr_acc && paddr_in == `FLP_REG_WORD) begin
					wr_d     = pwdata_in[15:0];
					is_cmd_d = 1'b0;
					cnt_d    = 8'h0;
					hs_d     = H_SETUP;
				end
			end
			H_SETUP: begin
				cnt_d = cnt_q + 8'h1;
				if (cnt_q == 8'(`FLP_CMD_SETUP_CYC - 1)) begin
					cstb_n_d = ~is_cmd_q;
					dstb_n_d = is_cmd_q;
					cnt_d    = 8'h0;
					hs_d     = H_PULSE;
				end
			end
			H_PULSE: begin
				cnt_d = cnt_q + 8'h1;
				if (cnt_q == 8'(`FLP_STROBE_CYC - 1)) begin
					cstb_n_d = 1'b1;
					dstb_n_d = 1'b1;
					hs_d     = H_IDLE;
				end
			end
			default: begin
				hs_d = H_IDLE;
			end
		endcase
	end

	// Strobe sequencer and registers, flops.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			hs_q     <= H_IDLE;
			cnt_q    <= 8'h0;
			is_cmd_q <= 1'b0;
			cmd_q    <= 16'h0;
			wr_q     <= 16'h0;
			cstb_n_q <= 1'b1;
			dstb_n_q <= 1'b1;
			rdat_q   <= 16'h0;
			ist_q    <= `FLP_IRQ_RST;
			ien_q    <= `FLP_IRQ_RST;
		end else begin
			hs_q     <= hs_d;
			cnt_q    <= cnt_d;
			is_cmd_q <= is_cmd_d;
			cmd_q    <= cmd_d;
			wr_q     <= wr_d;
			cstb_n_q <= cstb_n_d;
			dstb_n_q <= dstb_n_d;
			rdat_q   <= rdat_d;
			ist_q    <= ist_d;
			ien_q    <= ien_d;
		end
	end

	// Read mux; zero wait states keep the slave simple.
	always_comb begin
		prdata_out = 32'h0;
		case (paddr_in)
			`FLP_REG_CMD:      prdata_out = {16'h0, cmd_q};
			`FLP_REG_RDATA:    prdata_out = {16'h0, rdat_q};
			`FLP_REG_STATUS:   prdata_out = {27'h0, hs_q != H_IDLE,
			                                 sync_q};
			`FLP_REG_IRQ_STAT: prdata_out = {29'h0, ist_q};
			`FLP_REG_IRQ_EN:   prdata_out = {29'h0, ien_q};
			default:           prdata_out = 32'h0;
		endcase
	end

	assign pready_out           = 1'b1;
	assign pslverr_out          = psel_in & penable_in & ~mapped(paddr_in);
	assign irq_out              = |(ist_q & ien_q);
	assign link.cmd_word        = cmd_q;
	assign link.wr_data         = wr_q;
	assign link.command_pulse_n = cstb_n_q;
	assign link.word_strobe_n   = dstb_n_q;

endmodule : floppy_host_end

// ---- test/floppy_link_sva.sv ----
// Checker for the wires between the host end and the device end.
// Assumes one clock for both ends and a synchronous active-high reset.
`timescale 1ns/1ps
module floppy_link_sva #(
	parameter int REPLY_MAX_CYCLES = 6400
) (
	// Clock and reset.
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	// Host to device.
	input wire logic [15:0] cmd_word,
	input wire logic        command_pulse_n,
	input wire logic [15:0] wr_data,
	input wire logic        word_strobe_n,
	// Device to host.
	input wire logic [15:0] rd_data,
	input wire logic        word_request_flag,
	input wire logic        formatter_idle,
	input wire logic        late_service_flag,
	input wire logic        crc_fault_flag
);
	logic [15:0] low_q;
	logic [15:0] low_d;
	logic [15:0] req_q;
	logic [15:0] req_d;

	// Run lengths are counted here because a repetition cannot reach 300.
	always_comb begin
		low_d = command_pulse_n ? 16'h0 : low_q + 16'h1;
		req_d = word_request_flag ? req_q + 16'h1 : 16'h0;
	end

	// The counters only register their next values.
	always_ff @(posedge core_clk_in) begin
		low_q <= sys_rst_in ? 16'h0 : low_d;
		req_q <= sys_rst_in ? 16'h0 : req_d;
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	AST_CMD_WIDTH: assert property ($rose(command_pulse_n) |->
		low_q >= 16'h32 && low_q <= 16'h96) else $error("strobe width");
	AST_CMD_SETTLE: assert property ($fell(command_pulse_n) |->
		$past(cmd_word, 5) == cmd_word) else $error("command not settled");
	AST_WDATA_HOLD: assert property (!word_strobe_n |->
		$stable(wr_data)) else $error("write data moved");
	AST_RDATA_SET: assert property ($rose(word_request_flag) |->
		$stable(rd_data)) else $error("read data moved");
	AST_NO_EARLY_EXEC: assert property (
		$fell(command_pulse_n) && formatter_idle |=> formatter_idle [*8])
		else $error("command ran on leading edge");
	AST_IDLE_DROP: assert property (
		$rose(command_pulse_n) && formatter_idle |-> ##[1:8] !formatter_idle)
		else $error("idle did not drop");
	AST_REQ_DROP: assert property (
		word_request_flag && $rose(word_strobe_n) |-> ##[0:6] !word_request_flag)
		else $error("request not dropped");
	AST_REQ_WINDOW: assert property (word_request_flag |->
		req_q <= 16'(REPLY_MAX_CYCLES + 4)) else $error("window overrun");
	AST_FLAG_KEEP: assert property (
		$fell(late_service_flag) || $fell(crc_fault_flag) |-> !command_pulse_n)
		else $error("flag cleared without command");
	AST_REQ_BUSY: assert property (word_request_flag |->
		!formatter_idle) else $error("request while idle");
endmodule : floppy_link_sva

// ---- test/floppy_host_handshake_tb.sv ----
// Testbench joining the host end and the device end over the link.
// Assumes the design files are compiled first; drives APB and disk side.
`timescale 1ns/1ps
`include "floppy_consts.svh"
module floppy_host_handshake_tb;
	localparam int WORDS = 4;
	localparam int REPLY = 300;
	logic        core_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        disk_ready = 1'b0;
	logic        disk_slot = 1'b0;
	logic [15:0] disk_rd_data = 16'h0;
	logic        crc_error = 1'b0;
	logic        cmd_start;
	logic [15:0] cmd_out;
	logic        wr_valid;
	logic [15:0] wr_word;
	logic [31:0] rdv;
	logic        errv;
	logic [15:0] wq[$];
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc_cnt = 0;

	floppy_link_if floppy_link_if_inst ();

	floppy_host_end floppy_host_end_inst (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
		.link(floppy_link_if_inst.host));

	floppy_device_end #(.ACCESS_MIN_CYCLES(50), .REPLY_MAX_CYCLES(REPLY),
		.SECTOR_WORDS(WORDS)) floppy_device_end_inst (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.link(floppy_link_if_inst.dev), .disk_ready_in(disk_ready),
		.disk_slot_in(disk_slot), .disk_rd_data_in(disk_rd_data),
		.crc_error_in(crc_error), .cmd_start_out(cmd_start),
		.cmd_out(cmd_out), .disk_wr_valid_out(wr_valid),
		.disk_wr_data_out(wr_word));

	floppy_link_sva #(.REPLY_MAX_CYCLES(REPLY)) floppy_link_sva_inst (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.cmd_word(floppy_link_if_inst.cmd_word),
		.command_pulse_n(floppy_link_if_inst.command_pulse_n),
		.wr_data(floppy_link_if_inst.wr_data),
		.word_strobe_n(floppy_link_if_inst.word_strobe_n),
		.rd_data(floppy_link_if_inst.rd_data),
		.word_request_flag(floppy_link_if_inst.word_request_flag),
		.formatter_idle(floppy_link_if_inst.formatter_idle),
		.late_service_flag(floppy_link_if_inst.late_service_flag),
		.crc_fault_flag(floppy_link_if_inst.crc_fault_flag));

	// The clock toggles every half period of 5 ns.
	always #5 core_clk_in = ~core_clk_in;

	// Disk writes are logged at the falling edge, where they have settled.
	always @(negedge core_clk_in) begin
		if (wr_valid === 1'b1) wq.push_back(wr_word);
	end

	// A hang ends the run as a failure instead of running forever.
	always @(posedge core_clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer; read data and error are taken at the pready edge.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		do @(posedge core_clk_in); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic probe(input int sel);
		case (sel)
			0: probe = floppy_link_if_inst.word_request_flag;
			1: probe = floppy_link_if_inst.formatter_idle;
			default: probe = cmd_start;
		endcase
	endfunction : probe

	// Bounded wait on an output, sampled away from the active edge.
	task automatic await(input int sel, input logic lvl, input int lim);
		for (int k = 0; k < lim && probe(sel) !== lvl; k++) begin
			@(negedge core_clk_in);
		end
	endtask : await

	task automatic slot(input logic [15:0] d);
		@(posedge core_clk_in);
		disk_slot <= 1'b1;
		disk_rd_data <= d;
		@(posedge core_clk_in);
		disk_slot <= 1'b0;
	endtask : slot

	// Idle status after reset, and an unmapped offset.
	task automatic t_regs();
		apb(1'b1, `FLP_REG_IRQ_CLR, 32'h7);
		apb(1'b0, `FLP_REG_STATUS, 32'h0);
		check("status", rdv, 32'h2);
		apb(1'b0, 8'h1c, 32'h0);
		check("unmapped", {errv, rdv[30:0]}, 32'h80000000);
	endtask : t_regs

	// One sector; words from index answer on are left unanswered.
	task automatic t_sector(input floppy_pkg::op_e op, input int answer,
		input logic [31:0] status);
		floppy_pkg::cmd_s c;
		logic [15:0] exp_q[$];
		logic rd_op;
		rd_op = (op == floppy_pkg::OP_READ);
		c = '{1'b0, op, 2'h1, 7'h4c, 4'hd};
		wq.delete();
		disk_ready <= 1'b0;
		apb(1'b1, `FLP_REG_CMD, {16'h0, c});
		await(2, 1'b1, 400);
		check("cmd_out", {16'h0, cmd_out}, {16'h0, c});
		@(posedge core_clk_in);
		disk_ready <= 1'b1;
		slot(16'h0);
		await(0, 1'b1, 20);
		check("early_req", 32'(probe(0)), 32'h0);
		repeat (60) @(negedge core_clk_in);
		for (int i = 0; i <= WORDS; i++) begin
			slot(16'ha500 + 16'(i));
			if (i == WORDS) break;
			if (rd_op && i == 1) crc_error <= 1'b1;
			await(0, 1'b1, 20);
			@(posedge core_clk_in);
			crc_error <= 1'b0;
			check("req", 32'(probe(0)), 32'(i <= answer));
			if (rd_op) begin
				// The host latches read data three cycles after the request.
				repeat (2) @(posedge core_clk_in);
				apb(1'b0, `FLP_REG_RDATA, 32'h0);
				check("rdata", {16'h0, rdv[15:0]}, 32'ha500 + i);
			end
			if (i < answer) begin
				apb(1'b1, `FLP_REG_WORD, 32'h5a00 + i);
				exp_q.push_back(16'h5a00 + 16'(i));
				await(0, 1'b0, 200);
				check("req_drop", 32'(probe(0)), 32'h0);
			end else exp_q.push_back(16'h0);
			repeat (330) @(negedge core_clk_in);
		end
		await(1, 1'b1, 20);
		check("idle", 32'(probe(1)), 32'h1);
		repeat (5) @(negedge core_clk_in);
		apb(1'b0, `FLP_REG_STATUS, 32'h0);
		check("flags", rdv, status);
		apb(1'b0, `FLP_REG_IRQ_STAT, 32'h0);
		check("irq_stat", rdv, {29'h0, !rd_op, 2'h3});
		if (!rd_op) begin
			check("wr_count", wq.size(), WORDS);
			foreach (exp_q[i]) check("wr_word", wq[i], exp_q[i]);
		end
	endtask : t_sector

	// Seek clears the late flag; select raises the done interrupt, which is then masked.
	task automatic t_select();
		floppy_pkg::cmd_s c;
		// A seek with the head already on track returns idle at once.
		disk_ready <= 1'b1;
		c = '{1'b0, floppy_pkg::OP_SEEK, 2'h3, 7'h05, 4'h2};
		apb(1'b1, `FLP_REG_CMD, {16'h0, c});
		await(2, 1'b1, 400);
		check("seek_cmd", {16'h0, cmd_out}, {16'h0, c});
		await(1, 1'b1, 20);
		check("seek_idle", 32'(probe(1)), 32'h1);
		repeat (8) @(negedge core_clk_in);
		c = '{1'b0, floppy_pkg::OP_SELECT, 2'h2, 7'h4c, 4'hf};
		apb(1'b1, `FLP_REG_IRQ_CLR, 32'h7);
		apb(1'b1, `FLP_REG_IRQ_EN, 32'h1);
		@(negedge core_clk_in);
		check("irq_quiet", irq, 32'h0);
		apb(1'b1, `FLP_REG_CMD, {16'h0, c});
		await(2, 1'b1, 400);
		check("sel_cmd", {16'h0, cmd_out}, {16'h0, c});
		repeat (8) @(negedge core_clk_in);
		check("irq_done", irq, 32'h1);
		apb(1'b1, `FLP_REG_IRQ_EN, 32'h0);
		@(negedge core_clk_in);
		check("irq_mask", irq, 32'h0);
		apb(1'b1, `FLP_REG_IRQ_CLR, 32'h1);
		apb(1'b0, `FLP_REG_STATUS, 32'h0);
		check("cleared", rdv, 32'h2);
	endtask : t_select

	// Main sequence: reset, then each scenario in turn.
	initial begin
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		repeat (5) @(posedge core_clk_in);
		t_regs();
		t_sector(floppy_pkg::OP_READ, WORDS, 32'ha);
		t_sector(floppy_pkg::OP_WRITE, 2, 32'h6);
		t_select();
		tally_and_finish();
	end
endmodule : floppy_host_handshake_tb
